/* sec_pkg.sv */
package sec_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned SYS_CLK_HZ = 100_000_000;
  localparam int unsigned TWO_WIRE_HZ = 100_000;
  localparam int unsigned THREE_WIRE_HZ = 1_000_000;
  localparam int unsigned NO_RESP_MS = 30;
  localparam int unsigned TWO_WIRE_QTR_CYC = SYS_CLK_HZ / (TWO_WIRE_HZ * 4);
  localparam int unsigned THREE_WIRE_QTR_CYC = SYS_CLK_HZ / (THREE_WIRE_HZ * 4);
  localparam int unsigned NO_RESP_CYC = (SYS_CLK_HZ / 1000) * NO_RESP_MS;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // ****************************************
  // Encodings and reset values
  // ****************************************
  localparam logic [3:0] CTRL_CODE = 4'hA;
  localparam int unsigned ABITS_BASE = 7;
  localparam logic [15:0] LOCATION_RST = 16'h0000;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [1:0] W3_OP_READ = 2'h2;
  localparam logic [1:0] W3_OP_WRITE = 2'h1;
  localparam logic [1:0] W3_OP_ERASE = 2'h3;
  localparam logic [1:0] W3_OP_MISC = 2'h0;
  localparam logic [1:0] W3_EXT_WREN = 2'h3;
  localparam logic [1:0] W3_EXT_WRDIS = 2'h0;
  localparam logic [1:0] W3_EXT_ERALL = 2'h2;
  localparam logic [1:0] W3_EXT_WRALL = 2'h1;

  typedef enum logic [2:0] {
    CMD_READ = 3'b000, CMD_WRITE_DISABLE = 3'b001, CMD_WRITE_ENABLE = 3'b010, CMD_WRITE = 3'b011,
    CMD_WRITE_ALL = 3'b100, CMD_ERASE_ALL = 3'b101, CMD_ERASE = 3'b110, CMD_RELOAD = 3'b111
  } sec_cmd_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_STEP = 3'b001, S_BIT = 3'b010, S_START = 3'b011,
    S_STOP = 3'b100, S_CSOFF = 3'b101, S_POLL = 3'b110, S_END = 3'b111
  } sec_state_t;

endpackage : sec_pkg

/* sec_ctrl.sv */
// Behaviour
// - Type and size taken from straps once
// - Two-wire: open-drain data/clock, unused pins low
// - Three-wire: input only data-in, pull-down, drive others
// - Loader running blocks software command access
// - Three-wire supports all eight commands
// - Two-wire: only read, write, reload run
// - Loader issues read commands only
// - Busy set starts command, hardware clears it
// - Read byte in data register when busy clears
// - No response in 30 ms aborts, flags
// - Loader reads device after reset
// - Two-wire bus clocked at 100 kHz
// - Missing acknowledge aborts and flags
// - All address bits of size range driven
`timescale 1ns/1ps
`default_nettype none
module sec_ctrl import sec_pkg::*; #(
  parameter int unsigned TIMEOUT_CYC = NO_RESP_CYC,
  parameter int unsigned LOAD_BYTES = 16
) (
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  input wire logic TYPE_STRAP_I,
  input wire logic [1:0] SIZE_STRAP_I,
  input wire logic CMD_WR_I,
  input wire logic [2:0] CMD_CODE_I,
  input wire logic [15:0] LOCATION_I,
  input wire logic CMD_BUSY_I,
  input wire logic NO_RESP_CLR_I,
  input wire logic DATA_WR_I,
  input wire logic [7:0] DATA_I,
  output logic CMD_BUSY_O,
  output logic NO_RESPONSE_O,
  output logic [2:0] CMD_CODE_O,
  output logic [15:0] LOCATION_O,
  output logic [7:0] DATA_O,
  output logic LOADER_ACTIVE_O,
  output logic LD_WR_O,
  output logic [15:0] LD_ADDR_O,
  output logic [7:0] LD_DATA_O,
  input wire logic TWOWIRE_DATA_PIN_I,
  output logic TWOWIRE_DATA_PIN_O,
  output logic TWOWIRE_DATA_PIN_OE_O,
  output logic TWOWIRE_DATA_PD_EN_O,
  input wire logic TWOWIRE_CLOCK_PIN_I,
  output logic TWOWIRE_CLOCK_PIN_O,
  output logic TWOWIRE_CLOCK_PIN_OE_O,
  output logic CHIP_SELECT_PIN_O,
  output logic CHIP_SELECT_PIN_OE_O,
  output logic SERIAL_OUT_PIN_O,
  output logic SERIAL_OUT_PIN_OE_O
);
  localparam int TMO_W = $clog2(TIMEOUT_CYC + 1);
  localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(TIMEOUT_CYC - 1);
  localparam logic [15:0] LD_LAST = 16'(LOAD_BYTES - 1);

  logic [4:0] sync1_q, sync2_q;
  logic [1:0] init_q, size_q;
  logic cfg_ok_q, type_q, busy_q, no_resp_q, reload_q, ld_active_q, ld_wr_q;
  logic [2:0] cmd_q;
  logic [15:0] loc_q, addr_q, ld_idx_q, ld_addr_q;
  logic [7:0] data_q, wdat_q, ld_data_q, tcnt_q;
  sec_state_t st_q, step_st_w;
  sec_cmd_t op_q, go_cmd_w;
  logic [3:0] step_q, eff_w;
  logic [1:0] ph_q, w3_op_w, w3_ext_w;
  logic [31:0] sh_q, step_sh_w, w3_word_w;
  logic [4:0] n_q, step_n_w, abits_w, w3_n_w;
  logic [8:0] rx_q;
  logic owner_q, abort_q, chk_q, sda_q, scl_q, cs_q, do_q, step_rx_w;
  logic [TMO_W-1:0] tmo_cnt_q;

  // ****************************************
  // Pin synchronisers and strap capture
  // ****************************************
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end else begin
      sync1_q <= {TWOWIRE_DATA_PIN_I, TWOWIRE_CLOCK_PIN_I, TYPE_STRAP_I, SIZE_STRAP_I};
      sync2_q <= sync1_q;
    end
  end

  wire din_w = sync2_q[4];
  wire scl_in_w = sync2_q[3];
  wire cfg_now_w = !cfg_ok_q && (init_q == STRAP_SETTLE);

  // Straps share pins with the serial bus, so pins stay undriven until captured
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      init_q <= 2'h0;
      cfg_ok_q <= 1'b0;
      type_q <= 1'b0;
      size_q <= 2'h0;
    end else if (!cfg_ok_q) begin
      init_q <= init_q + 2'h1;
      if (cfg_now_w) begin
        cfg_ok_q <= 1'b1;
        type_q <= sync2_q[2];
        size_q <= sync2_q[1:0];
      end
    end
  end

  // ****************************************
  // Command decode and arbitration
  // ****************************************
  wire sw_wr_ok_w = CMD_WR_I && !busy_q && !ld_active_q;
  wire sw_start_w = sw_wr_ok_w && CMD_BUSY_I;
  wire eng_idle_w = (st_q == S_IDLE) && cfg_ok_q;
  wire ld_go_w = eng_idle_w && ld_active_q;
  wire sw_go_w = eng_idle_w && busy_q && !ld_active_q && !reload_q;
  wire eng_go_w = ld_go_w || sw_go_w;
  wire eng_end_w = (st_q == S_END);
  assign go_cmd_w = ld_go_w ? CMD_READ : sec_cmd_t'(cmd_q);
  wire legal_w = !type_q || go_cmd_w inside {CMD_READ, CMD_WRITE, CMD_RELOAD};
  wire [7:0] rx_byte_w = type_q ? rx_q[8:1] : rx_q[7:0];
  wire tmo_set_w = eng_end_w && abort_q;
  wire ld_finish_w = eng_end_w && owner_q && (abort_q || ld_idx_q == LD_LAST);
  wire sw_reload_w = eng_end_w && !owner_q && (op_q == CMD_RELOAD);

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      cmd_q <= CMD_READ;
      loc_q <= LOCATION_RST;
      busy_q <= 1'b0;
      no_resp_q <= 1'b0;
      data_q <= DATA_RST;
      reload_q <= 1'b0;
    end else begin
      if (sw_wr_ok_w) begin
        cmd_q <= CMD_CODE_I;
        loc_q <= LOCATION_I;
      end
      if (sw_start_w)
        busy_q <= 1'b1;
      else if ((eng_end_w && !owner_q && op_q != CMD_RELOAD) || (reload_q && ld_finish_w))
        busy_q <= 1'b0;
      if (tmo_set_w)
        no_resp_q <= 1'b1;
      else if (sw_start_w || NO_RESP_CLR_I)
        no_resp_q <= 1'b0;
      if (eng_end_w && !owner_q && op_q == CMD_READ && !abort_q)
        data_q <= rx_byte_w;
      else if (DATA_WR_I && !busy_q)
        data_q <= DATA_I;
      if (sw_reload_w)
        reload_q <= 1'b1;
      else if (ld_finish_w)
        reload_q <= 1'b0;
    end
  end

  // ****************************************
  // Configuration loader
  // ****************************************
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ld_active_q <= 1'b0;
      ld_idx_q <= 16'h0000;
      ld_wr_q <= 1'b0;
      ld_addr_q <= 16'h0000;
      ld_data_q <= DATA_RST;
    end else begin
      ld_wr_q <= eng_end_w && owner_q && !abort_q;
      if (cfg_now_w || sw_reload_w) begin
        ld_active_q <= 1'b1;
        ld_idx_q <= 16'h0000;
      end else if (ld_finish_w) begin
        ld_active_q <= 1'b0;
      end else if (eng_end_w && owner_q) begin
        ld_idx_q <= ld_idx_q + 16'h0001;
      end
      if (eng_end_w && owner_q) begin
        ld_addr_q <= ld_idx_q;
        ld_data_q <= rx_byte_w;
      end
    end
  end

  // ****************************************
  // Step table
  // ****************************************
  // Single-byte parts carry the upper location bits in the control byte
  wire [2:0] blk_w = size_q[0] ? 3'h0 : addr_q[10:8];
  wire rd_w = (op_q == CMD_READ);
  wire slow_w = op_q inside {CMD_WRITE, CMD_WRITE_ALL, CMD_ERASE, CMD_ERASE_ALL};
  assign eff_w = (!size_q[0] && step_q >= 4'h2) ? step_q + 4'h1 : step_q;
  assign abits_w = 5'(ABITS_BASE) + {3'h0, size_q};
  assign w3_op_w = rd_w ? W3_OP_READ : (op_q == CMD_WRITE) ? W3_OP_WRITE :
                   (op_q == CMD_ERASE) ? W3_OP_ERASE : W3_OP_MISC;
  assign w3_ext_w = (op_q == CMD_WRITE_ENABLE) ? W3_EXT_WREN : (op_q == CMD_ERASE_ALL) ? W3_EXT_ERALL :
                    (op_q == CMD_WRITE_ALL) ? W3_EXT_WRALL : W3_EXT_WRDIS;
  wire [15:0] addr_al_w = (w3_op_w == W3_OP_MISC) ? {w3_ext_w, 14'h0000} : addr_q << (5'h10 - abits_w);
  assign w3_word_w = {1'b1, w3_op_w, addr_al_w, 13'h0000} | ({wdat_q, 24'h00_0000} >> (5'h03 + abits_w));
  assign w3_n_w = 5'h03 + abits_w + (op_q inside {CMD_WRITE, CMD_WRITE_ALL} ? 5'h08 : 5'h00);

  always_comb begin
    logic [7:0] tx_byte;
    tx_byte = 8'hFF;
    step_st_w = S_END;
    step_rx_w = 1'b0;
    step_n_w = 5'h09;
    if (type_q) begin
      case (eff_w)
        4'h0: step_st_w = S_START;
        4'h1: begin
          step_st_w = S_BIT;
          tx_byte = {CTRL_CODE, blk_w, 1'b0};
        end
        4'h2: begin
          step_st_w = S_BIT;
          tx_byte = addr_q[15:8];
        end
        4'h3: begin
          step_st_w = S_BIT;
          tx_byte = addr_q[7:0];
        end
        4'h4: begin
          step_st_w = rd_w ? S_START : S_BIT;
          tx_byte = rd_w ? 8'hFF : wdat_q;
        end
        4'h5: begin
          step_st_w = rd_w ? S_BIT : S_STOP;
          tx_byte = {CTRL_CODE, blk_w, 1'b1};
        end
        4'h6: begin
          step_st_w = rd_w ? S_BIT : S_END;
          step_rx_w = 1'b1;
        end
        4'h7: step_st_w = rd_w ? S_STOP : S_END;
        default: step_st_w = S_END;
      endcase
      step_sh_w = {tx_byte, 1'b1, 23'h00_0000};
    end else begin
      step_sh_w = w3_word_w;
      step_n_w = w3_n_w;
      case (step_q)
        4'h0: step_st_w = S_BIT;
        4'h1: begin
          step_st_w = rd_w ? S_BIT : S_CSOFF;
          step_rx_w = 1'b1;
          step_n_w = 5'h08;
        end
        4'h2: step_st_w = rd_w ? S_CSOFF : (slow_w ? S_POLL : S_END);
        4'h3: step_st_w = (slow_w && !rd_w) ? S_CSOFF : S_END;
        default: step_st_w = S_END;
      endcase
    end
  end

  // ****************************************
  // Serial engine
  // ****************************************
  wire [7:0] qtr_w = type_q ? 8'(TWO_WIRE_QTR_CYC - 1) : 8'(THREE_WIRE_QTR_CYC - 1);
  wire tick_w = (tcnt_q == 8'h00);
  // A device holding the clock low only stretches the bit; the 30 ms watchdog bounds it
  wire hold_w = type_q && (ph_q == 2'h2) && !scl_in_w && (st_q inside {S_BIT, S_START, S_STOP});
  wire adv_w = tick_w && !hold_w;
  wire expire_w = !(st_q inside {S_IDLE, S_END}) && (tmo_cnt_q == TMO_LAST);

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      tcnt_q <= 8'h00;
      tmo_cnt_q <= '0;
    end else begin
      tcnt_q <= adv_w ? qtr_w : (tick_w ? tcnt_q : tcnt_q - 8'h01);
      tmo_cnt_q <= (st_q == S_IDLE) ? '0 : (expire_w ? tmo_cnt_q : tmo_cnt_q + 1'b1);
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      st_q <= S_IDLE;
      op_q <= CMD_READ;
      addr_q <= LOCATION_RST;
      wdat_q <= DATA_RST;
      owner_q <= 1'b0;
      abort_q <= 1'b0;
      chk_q <= 1'b0;
      step_q <= 4'h0;
      ph_q <= 2'h0;
      sh_q <= 32'h0000_0000;
      n_q <= 5'h00;
      rx_q <= 9'h000;
      sda_q <= 1'b1;
      scl_q <= 1'b1;
      cs_q <= 1'b0;
      do_q <= 1'b0;
    end else if (expire_w) begin
      abort_q <= 1'b1;
      st_q <= S_END;
    end else begin
      case (st_q)
        S_IDLE: begin
          sda_q <= 1'b1;
          scl_q <= type_q;
          cs_q <= 1'b0;
          if (eng_go_w) begin
            op_q <= go_cmd_w;
            addr_q <= ld_go_w ? ld_idx_q : loc_q;
            wdat_q <= data_q;
            owner_q <= ld_go_w;
            abort_q <= 1'b0;
            step_q <= 4'h0;
            st_q <= (legal_w && go_cmd_w != CMD_RELOAD) ? S_STEP : S_END;
          end
        end
        S_STEP: begin
          ph_q <= 2'h0;
          sh_q <= step_sh_w;
          n_q <= step_n_w;
          chk_q <= type_q && !step_rx_w;
          if (!type_q && step_st_w inside {S_BIT, S_POLL})
            cs_q <= 1'b1;
          st_q <= step_st_w;
        end
        S_BIT: if (adv_w) begin
          ph_q <= ph_q + 2'h1;
          case (ph_q)
            2'h0: begin
              sda_q <= sh_q[31];
              do_q <= sh_q[31];
            end
            2'h1: scl_q <= 1'b1;
            2'h2: begin
              rx_q <= {rx_q[7:0], din_w};
              if (chk_q && n_q == 5'h01 && din_w)
                abort_q <= 1'b1;
            end
            default: begin
              scl_q <= 1'b0;
              sh_q <= {sh_q[30:0], 1'b0};
              n_q <= n_q - 5'h01;
              if (n_q == 5'h01) begin
                step_q <= step_q + 4'h1;
                st_q <= abort_q ? S_STOP : S_STEP;
              end
            end
          endcase
        end
        S_START: if (adv_w) begin
          ph_q <= ph_q + 2'h1;
          case (ph_q)
            2'h0: sda_q <= 1'b1;
            2'h1: scl_q <= 1'b1;
            2'h2: sda_q <= 1'b0;
            default: begin
              scl_q <= 1'b0;
              step_q <= step_q + 4'h1;
              st_q <= S_STEP;
            end
          endcase
        end
        S_STOP: if (adv_w) begin
          ph_q <= ph_q + 2'h1;
          case (ph_q)
            2'h0: sda_q <= 1'b0;
            2'h1: scl_q <= 1'b1;
            2'h2: sda_q <= 1'b1;
            default: begin
              step_q <= step_q + 4'h1;
              st_q <= abort_q ? S_END : S_STEP;
            end
          endcase
        end
        S_CSOFF: if (adv_w) begin
          cs_q <= 1'b0;
          step_q <= step_q + 4'h1;
          st_q <= S_STEP;
        end
        S_POLL: if (adv_w && din_w) begin
          step_q <= step_q + 4'h1;
          st_q <= S_STEP;
        end
        S_END: st_q <= S_IDLE;
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign CMD_BUSY_O = busy_q;
  assign NO_RESPONSE_O = no_resp_q;
  assign CMD_CODE_O = cmd_q;
  assign LOCATION_O = loc_q;
  assign DATA_O = data_q;
  assign LOADER_ACTIVE_O = ld_active_q;
  assign LD_WR_O = ld_wr_q;
  assign LD_ADDR_O = ld_addr_q;
  assign LD_DATA_O = ld_data_q;
  assign TWOWIRE_DATA_PIN_O = 1'b0;
  assign TWOWIRE_DATA_PIN_OE_O = cfg_ok_q && type_q && !sda_q;
  assign TWOWIRE_DATA_PD_EN_O = cfg_ok_q && !type_q;
  assign TWOWIRE_CLOCK_PIN_O = !type_q && scl_q;
  assign TWOWIRE_CLOCK_PIN_OE_O = cfg_ok_q && (!type_q || !scl_q);
  assign CHIP_SELECT_PIN_O = !type_q && cs_q;
  assign CHIP_SELECT_PIN_OE_O = cfg_ok_q;
  assign SERIAL_OUT_PIN_O = !type_q && do_q;
  assign SERIAL_OUT_PIN_OE_O = cfg_ok_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!NRST_I);

  property p_two_pins;
    cfg_ok_q && type_q |-> CHIP_SELECT_PIN_OE_O && !CHIP_SELECT_PIN_O && SERIAL_OUT_PIN_OE_O
      && !SERIAL_OUT_PIN_O && !TWOWIRE_DATA_PD_EN_O && !TWOWIRE_DATA_PIN_O;
  endproperty
  a_two_pins: assert property (p_two_pins) else $error("two-wire pin setup wrong");
  property p_three_pins;
    cfg_ok_q && !type_q |-> !TWOWIRE_DATA_PIN_OE_O && TWOWIRE_DATA_PD_EN_O && TWOWIRE_CLOCK_PIN_OE_O;
  endproperty
  a_three_pins: assert property (p_three_pins) else $error("three-wire pin setup wrong");
  property p_loader_excl;
    ld_active_q && !busy_q && CMD_WR_I && CMD_BUSY_I |=> !busy_q && $stable(cmd_q);
  endproperty
  a_loader_excl: assert property (p_loader_excl) else $error("command taken during loader");
  property p_two_illegal;
    eng_go_w && type_q && !legal_w |=> st_q == S_END ##1 st_q == S_IDLE;
  endproperty
  a_two_illegal: assert property (p_two_illegal) else $error("illegal two-wire command ran");
  property p_loader_read;
    ld_go_w |=> op_q == CMD_READ && owner_q;
  endproperty
  a_loader_read: assert property (p_loader_read) else $error("loader issued non-read");
  property p_busy_clear;
    eng_end_w && !owner_q && op_q != CMD_RELOAD |=> !busy_q;
  endproperty
  a_busy_clear: assert property (p_busy_clear) else $error("busy not cleared at end");
  property p_read_data;
    eng_end_w && !owner_q && rd_w && !abort_q |=> DATA_O == $past(rx_byte_w) && !CMD_BUSY_O;
  endproperty
  a_read_data: assert property (p_read_data) else $error("read byte not in data register");
  property p_timeout;
    expire_w |=> st_q == S_END ##1 no_resp_q;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout did not flag");
  property p_nack;
    st_q == S_BIT && adv_w && ph_q == 2'h3 && n_q == 5'h01 && abort_q && !expire_w |=> st_q == S_STOP;
  endproperty
  a_nack: assert property (p_nack) else $error("missing acknowledge not aborted");
  property p_flag_hold;
    no_resp_q && !NO_RESP_CLR_I && !sw_start_w |=> no_resp_q;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("no-response flag lost");
  property p_boot_load;
    cfg_now_w |=> ld_active_q ##1 st_q == S_STEP;
  endproperty
  a_boot_load: assert property (p_boot_load) else $error("loader did not start");

  c_sw_read: cover property (eng_end_w && !owner_q && rd_w && !abort_q);
  c_loader_wr: cover property (ld_wr_q);
  c_nack_abort: cover property (tmo_set_w && type_q);
  c_reload: cover property (sw_reload_w);

endmodule : sec_ctrl
`default_nettype wire

/* sec_eeprom_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sec_eeprom_model #(
  parameter int ABITS = 7,
  parameter int WR_NS = 2000
) (
  input wire logic cs_i,
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic mute_i,
  output logic miso_o
);
  // ****************************************
  // Three-wire memory
  // ****************************************
  logic [7:0] mem [2**ABITS];
  logic [15:0] sh_q = 16'h0000;
  logic [7:0] rd_q = 8'h00;
  logic [1:0] op_q = 2'h0;
  logic [1:0] ext = 2'h0;
  logic [ABITS-1:0] adr_q = '0;
  logic wr_en_q = 1'b0;
  logic rd_act_q = 1'b0;
  logic bit_q = 1'b0;
  logic rdy_q = 1'b1;
  int cnt_q = 0;
  event wr_ev;
  task automatic fill(input logic [7:0] v);
    for (int i = 0; i < 2**ABITS; i++) mem[i] = v;
    ->wr_ev;
  endtask : fill
  initial for (int i = 0; i < 2**ABITS; i++) mem[i] = 8'(i) ^ 8'h5A;
  // Ready drops for WR_NS on each program cycle; a muted part never comes back
  always begin
    @(wr_ev);
    rdy_q = 1'b0;
    #(WR_NS);
    rdy_q = 1'b1;
  end
  always @(posedge sck_i) begin
    if (cs_i && (cnt_q != 0 || mosi_i)) begin
      sh_q = {sh_q[14:0], mosi_i};
      cnt_q++;
      if (cnt_q == 3 + ABITS) begin
        op_q = sh_q[ABITS+1:ABITS];
        adr_q = sh_q[ABITS-1:0];
        // Decoded in place: a continuous assign would lag the opcode checks below
        ext = adr_q[ABITS-1 -: 2];
        rd_act_q = (op_q == 2'h2);
        rd_q = mem[adr_q];
        if (op_q == 2'h3 && wr_en_q) fill_one(8'hFF);
        if (op_q == 2'h0 && ext == 2'h3) wr_en_q = 1'b1;
        if (op_q == 2'h0 && ext == 2'h0) wr_en_q = 1'b0;
        if (op_q == 2'h0 && ext == 2'h2 && wr_en_q) fill(8'hFF);
      end
      if (cnt_q == 11 + ABITS && wr_en_q && op_q == 2'h1) fill_one(sh_q[7:0]);
      if (cnt_q == 11 + ABITS && wr_en_q && op_q == 2'h0 && ext == 2'h1) fill(sh_q[7:0]);
    end
  end
  task automatic fill_one(input logic [7:0] v);
    mem[adr_q] = v;
    ->wr_ev;
  endtask : fill_one
  always @(negedge sck_i) begin
    if (cs_i && rd_act_q) begin
      bit_q = rd_q[7];
      rd_q = {rd_q[6:0], 1'b0};
    end
  end
  always @(negedge cs_i) begin
    cnt_q = 0;
    rd_act_q = 1'b0;
  end
  // Deselected, the pull-down holds the line low
  assign miso_o = !cs_i ? 1'b0 : (rd_act_q ? bit_q : (rdy_q && !mute_i));
endmodule : sec_eeprom_model
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sec_pkg::*;
  localparam int unsigned TMO = 20000;
  localparam int unsigned NLD = 2;
  logic clk = 1'b0, nrst = 1'b0, type_s = 1'b0, cmd_wr = 1'b0, cmd_busy = 1'b0;
  logic clr = 1'b0, data_wr = 1'b0, mute = 1'b0;
  logic [1:0] size_s = 2'h0;
  logic [2:0] code = 3'h0;
  logic [15:0] loc = 16'h0000;
  logic [7:0] din = 8'h00;
  logic busy, nresp, ld_act, ld_wr, sda_o, sda_oe, sda_pd, scl_o, scl_oe, cs_o, cs_oe, so_o, so_oe, miso;
  logic [2:0] code_o;
  logic [15:0] loc_o, ld_addr;
  logic [7:0] dout, ld_data;
  wire logic sda_w = sda_oe ? 1'b0 : (type_s ? 1'b1 : miso);
  wire logic scl_w = scl_oe ? scl_o : 1'b1;
  int err_count = 0, check_count = 0, nld = 0;
  always #5 clk = ~clk;
  sec_ctrl #(.TIMEOUT_CYC(TMO), .LOAD_BYTES(NLD)) sec_ctrl_inst (.CLK_SYS_I(clk), .NRST_I(nrst),
    .TYPE_STRAP_I(type_s), .SIZE_STRAP_I(size_s), .CMD_WR_I(cmd_wr), .CMD_CODE_I(code), .LOCATION_I(loc),
    .CMD_BUSY_I(cmd_busy), .NO_RESP_CLR_I(clr), .DATA_WR_I(data_wr), .DATA_I(din), .CMD_BUSY_O(busy),
    .NO_RESPONSE_O(nresp), .CMD_CODE_O(code_o), .LOCATION_O(loc_o), .DATA_O(dout), .LOADER_ACTIVE_O(ld_act),
    .LD_WR_O(ld_wr), .LD_ADDR_O(ld_addr), .LD_DATA_O(ld_data), .TWOWIRE_DATA_PIN_I(sda_w),
    .TWOWIRE_DATA_PIN_O(sda_o), .TWOWIRE_DATA_PIN_OE_O(sda_oe), .TWOWIRE_DATA_PD_EN_O(sda_pd),
    .TWOWIRE_CLOCK_PIN_I(scl_w), .TWOWIRE_CLOCK_PIN_O(scl_o), .TWOWIRE_CLOCK_PIN_OE_O(scl_oe),
    .CHIP_SELECT_PIN_O(cs_o), .CHIP_SELECT_PIN_OE_O(cs_oe), .SERIAL_OUT_PIN_O(so_o),
    .SERIAL_OUT_PIN_OE_O(so_oe));
  sec_eeprom_model sec_eeprom_model_inst (.cs_i(cs_o & cs_oe), .sck_i(scl_o & scl_oe), .mosi_i(so_o),
    .mute_i(mute), .miso_o(miso));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  function automatic logic [7:0] init_byte(input logic [15:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction : init_byte
  task automatic wait_lo(ref logic s, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (s !== 1'b0 && n < 50000);
    if (n >= 50000) begin
      check("wait_bound", 32'(n), 32'(0));
      final_report();
    end
  endtask : wait_lo
  task automatic wdat(input logic [7:0] d);
    @(posedge clk);
    din <= d;
    data_wr <= 1'b1;
    @(posedge clk);
    data_wr <= 1'b0;
  endtask : wdat
  task automatic cmd(input logic [2:0] c, input logic [15:0] l, output int n);
    @(posedge clk);
    code <= c;
    loc <= l;
    cmd_busy <= 1'b1;
    cmd_wr <= 1'b1;
    @(posedge clk);
    cmd_wr <= 1'b0;
    wait_lo(busy, n);
  endtask : cmd
  task automatic rd_chk(input logic [15:0] l, input logic [7:0] e);
    int n;
    cmd(CMD_READ, l, n);
    check("read_data", 32'(dout), 32'(e));
    check("cmd_readback", 32'({code_o, loc_o}), 32'({CMD_READ, l}));
  endtask : rd_chk
  task automatic do_reset(input logic t, input logic [1:0] s);
    @(posedge clk);
    nrst <= 1'b0;
    type_s <= t;
    size_s <= s;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
  endtask : do_reset
  always @(negedge clk) begin
    if (ld_wr === 1'b1 && !type_s) begin
      check("ld_addr", 32'(ld_addr), 32'(nld % NLD));
      nld++;
      check("ld_data", 32'(ld_data), 32'(sec_eeprom_model_inst.mem[ld_addr[6:0]]));
    end
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    int n;
    logic [7:0] d;
    logic [15:0] a;
    logic [2:0] tw_codes [5];
    tw_codes = '{CMD_WRITE_DISABLE, CMD_WRITE_ENABLE, CMD_WRITE_ALL, CMD_ERASE_ALL, CMD_ERASE};
    void'($urandom(36591));
    do_reset(1'b0, 2'h0);
    check("pins_3w", 32'({sda_oe, sda_pd, cs_oe, so_oe, scl_oe}), 32'(5'h0F));
    check("ld_run", 32'(ld_act), 32'(1));
    @(posedge clk);
    code <= CMD_ERASE_ALL;
    cmd_busy <= 1'b1;
    cmd_wr <= 1'b1;
    @(posedge clk);
    cmd_wr <= 1'b0;
    @(posedge clk);
    #1;
    check("busy_in_load", 32'(busy), 32'(0));
    check("cmd_kept", 32'({code_o, loc_o}), 32'({CMD_READ, LOCATION_RST}));
    wait_lo(ld_act, n);
    // The last loader byte is delivered in the same cycle the loader drops
    @(posedge clk);
    check("ld_count", 32'(nld), 32'(NLD));
    rd_chk(16'h0040, init_byte(16'h0040));
    $display("test loader done");
    cmd(CMD_WRITE_ENABLE, 16'h0000, n);
    repeat (4) begin
      a = 16'($urandom_range(127));
      d = 8'($urandom);
      wdat(d);
      cmd(CMD_WRITE, a, n);
      rd_chk(a, d);
    end
    cmd(CMD_WRITE_DISABLE, 16'h0000, n);
    wdat(~d);
    cmd(CMD_WRITE, a, n);
    rd_chk(a, d);
    cmd(CMD_WRITE_ENABLE, 16'h0000, n);
    cmd(CMD_ERASE, a, n);
    rd_chk(a, 8'hFF);
    wdat(8'h3C);
    cmd(CMD_WRITE_ALL, 16'h0000, n);
    rd_chk(16'h007F, 8'h3C);
    cmd(CMD_ERASE_ALL, 16'h0000, n);
    rd_chk(16'h0011, 8'hFF);
    cmd(CMD_RELOAD, 16'h0000, n);
    @(posedge clk);
    check("reload_count", 32'(nld), 32'(2 * NLD));
    $display("test commands done");
    mute <= 1'b1;
    wdat(8'h11);
    cmd(CMD_WRITE, 16'h0005, n);
    check("tmo_len", 32'(n >= TMO - 4 && n <= TMO + 4), 32'(1));
    check("tmo_flag", 32'(nresp), 32'(1));
    repeat (10) @(posedge clk);
    #1;
    check("tmo_sticky", 32'(nresp), 32'(1));
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    @(posedge clk);
    #1;
    check("tmo_clear", 32'(nresp), 32'(0));
    mute <= 1'b0;
    $display("test timeout done");
    do_reset(1'b1, 2'h1);
    check("pins_2w", 32'({sda_o, scl_o, sda_pd, cs_o, cs_oe, so_o, so_oe}), 32'(7'h05));
    wait_lo(ld_act, n);
    check("ld_nack", 32'(nresp), 32'(1));
    foreach (tw_codes[i]) begin
      cmd(tw_codes[i], 16'h0000, n);
      check("tw_skip", 32'(n < 20), 32'(1));
      check("flag_restart", 32'(nresp), 32'(0));
    end
    cmd(CMD_READ, 16'h0012, n);
    check("tw_nack", 32'(nresp && n < TMO), 32'(1));
    $display("test two-wire done");
    final_report();
  end
endmodule : tb_top
`default_nettype wire
